// *** design/dtc_ctrl.sv ***
// Controller end: timing converter registers on APB and link driver.
// Assumes an APB master on pclk and a device end on the link.
// How it works
// - Eight-beat or on-the-fly chop: write at latency+4.
// - Fixed four-beat chop: write at latency+2.
// - Parity with DLL off extends refresh time.
// - Select-to-command minimum: max of 3, 3.748ns.
// - Clock period rounds up to whole picoseconds.
// - Integer picosecond arithmetic throughout.
// - Presence-detect count truncates with 974/1000 added.
// - Other counts round the quotient upward.
// - Below 1600 MT/s use lowest grade values; the code only sets the slow status bit.
// - Turnaround value follows checking and masking setting.
// - Two-cycle preamble drives strobe one cycle earlier.
// - Device accepts rounded whole-cycle counts.
// - Spread accesses evenly over row addresses; commands carry no row address, so this is left to software.
//
// Implementation choices: register access over APB and the address map.
`include "dtc_cfg.svh"
module dtc_ctrl
    import dtc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    dtc_link_if.ctrl         link
);
    // ------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------
    // Presence-detect count: truncate(p/t + 974/1000).
    function automatic logic [31:0] dtc_spd(logic [31:0] p, logic [15:0] t);
        logic [47:0] num;
        logic [47:0] den;
        num = {16'h0, p} * `DTC_SCALE + {32'h0, t} * `DTC_ADJ;
        den = {32'h0, t} * `DTC_SCALE;
        if (t == 16'h0)
        begin
            return 32'h0;
        end
        return 32'(num / den);
    endfunction : dtc_spd

    // Other counts: ceiling of p/t.
    function automatic logic [31:0] dtc_ceil(logic [31:0] p, logic [15:0] t);
        logic [32:0] num;
        num = {1'b0, p} + {17'h0, t} - 33'h1;
        if (t == 16'h0)
        begin
            return 32'h0;
        end
        return 32'(num / {17'h0, t});
    endfunction : dtc_ceil

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] period_fs;   // Clock period in femtoseconds.
        logic [15:0] tck_ps;      // Rounded period in picoseconds.
        logic [31:0] spd_ps;      // Presence-detect parameter.
        logic [31:0] nonspd_ps;   // Other parameter.
        logic [31:0] cfg;         // Mode and option bits.
        logic [31:0] wtr_ps;      // Turnaround pair, off low, on high.
        logic [31:0] rfc_ps;      // Refresh cycle time.
        logic [31:0] spd_cyc;     // Converted results.
        logic [31:0] nsp_cyc;
        logic [31:0] rfc_cyc;
        logic [31:0] cal_cyc;
        logic [31:0] wtr_cyc;
        logic        recalc;      // Recompute next cycle.
        logic [1:0]  cmd_pend;    // Pending read, write.
        logic        link_clk;    // Divided command clock.
        logic        link_rst_n;  // Link reset.
        logic [4:0]  wr_lat;      // Write latency sent to the device.
        logic [4:0]  rd_lat;      // Read latency sent to the device.
        logic        cmd_wr;      // Launched commands.
        logic        cmd_rd;
        logic [1:0]  wr_sync;     // Synchronisers, first flop low.
        logic [1:0]  oe_sync;
        logic        wr_seen;     // Last synchronised levels.
        logic        oe_seen;
        logic [7:0]  wr_count;    // Internal write starts seen.
        logic [7:0]  oe_count;    // Strobe bursts seen.
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dtc_ctrl_st_t;

    dtc_ctrl_st_t st;             // Registered state.
    dtc_ctrl_st_t next_st;        // Next state.

    // Config field aliases.
    logic       par_en;           // Command/address parity enabled.
    logic       dll_off;          // DLL switched off.
    logic       crc_en;           // Write error checking.
    logic       data_masking;     // Data masking enabled.
    logic [4:0] parity_latency_cycles;
    logic       slow;             // Data rate below 1600 MT/s.
    logic       wr_acc;           // APB write access completes.
    logic [31:0] rd_val;          // Read mux result.
    logic        rd_ok;           // Address is mapped.

    assign par_en = st.cfg[0];
    assign dll_off = st.cfg[1];
    assign crc_en = st.cfg[2];
    assign data_masking = st.cfg[3];
    assign parity_latency_cycles = st.cfg[8:4];
    assign slow = (st.tck_ps > `DTC_SLOW_PS);
    assign wr_acc = psel && penable && st.pready && pwrite;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    // Unmapped addresses read zero and answer with an error.
    always_comb
    begin
        rd_ok = 1'b1;
        case (paddr)
            `DTC_OFS_PERIOD: rd_val = st.period_fs;
            `DTC_OFS_SPD:    rd_val = st.spd_ps;
            `DTC_OFS_NONSPD: rd_val = st.nonspd_ps;
            `DTC_OFS_CFG:    rd_val = st.cfg;
            `DTC_OFS_WTR:    rd_val = st.wtr_ps;
            `DTC_OFS_RFC:    rd_val = st.rfc_ps;
            `DTC_OFS_SPDCYC: rd_val = st.spd_cyc;
            `DTC_OFS_NSPCYC: rd_val = st.nsp_cyc;
            `DTC_OFS_RFCCYC: rd_val = st.rfc_cyc;
            `DTC_OFS_CALCYC: rd_val = st.cal_cyc;
            `DTC_OFS_WTRCYC: rd_val = st.wtr_cyc;
            `DTC_OFS_STATUS: rd_val = {st.tck_ps, st.oe_count, st.wr_count[6:0], slow};
            `DTC_OFS_CMD:    rd_val = {30'h0, st.cmd_pend};
            default:
            begin
                rd_val = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [31:0] cal;
        logic        launch;
        cal = 32'h0;
        launch = 1'b0;
        next_st = st;
        // APB: answer registered in the setup cycle, one wait-free access.
        next_st.pready = psel && !penable;
        next_st.pslverr = psel && !penable && !rd_ok;
        next_st.prdata = (psel && !penable && !pwrite) ? rd_val : 32'h0;
        next_st.recalc = 1'b0;
        if (wr_acc && rd_ok)
        begin
            next_st.recalc = 1'b1;
            case (paddr)
                `DTC_OFS_PERIOD: next_st.period_fs = pwdata;
                `DTC_OFS_SPD:    next_st.spd_ps = pwdata;
                `DTC_OFS_NONSPD: next_st.nonspd_ps = pwdata;
                `DTC_OFS_CFG:    next_st.cfg = pwdata;
                `DTC_OFS_WTR:    next_st.wtr_ps = pwdata;
                `DTC_OFS_RFC:    next_st.rfc_ps = pwdata;
                default:
                begin
                    next_st.recalc = 1'b0;
                end
            endcase
        end
        // Round the period up to a whole picosecond.
        next_st.tck_ps = 16'(dtc_ceil(st.period_fs, 16'h3E8));
        // A new period must reach every count, not only a new parameter.
        if (next_st.tck_ps != st.tck_ps)
        begin
            next_st.recalc = 1'b1;
        end
        // Results follow one cycle behind the rounded period; the
        // division is deep, so a multicycle path is expected here.
        if (st.recalc)
        begin
            cal = dtc_ceil(`DTC_CAL_PS, st.tck_ps);
            next_st.spd_cyc = dtc_spd(st.spd_ps, st.tck_ps);
            next_st.nsp_cyc = dtc_ceil(st.nonspd_ps, st.tck_ps);
            next_st.cal_cyc = (cal > `DTC_CAL_MIN) ? cal : `DTC_CAL_MIN;
            next_st.rfc_cyc = dtc_ceil(st.rfc_ps, st.tck_ps)
                + ((par_en && dll_off) ? {27'h0, parity_latency_cycles} : 32'h0);
            // Mixed settings take the larger, checked value.
            next_st.wtr_cyc = (!crc_en && !data_masking)
                ? dtc_ceil({16'h0, st.wtr_ps[15:0]}, st.tck_ps)
                : dtc_ceil({16'h0, st.wtr_ps[31:16]}, st.tck_ps);
        end
        // Link clock is pclk over two; commands launch as it falls.
        next_st.link_clk = !st.link_clk;
        next_st.link_rst_n = 1'b1;
        // Latencies are registered so the link sees flop outputs only.
        next_st.wr_lat = `DTC_RST_WL + next_st.cfg[17:13];
        next_st.rd_lat = `DTC_RST_RL + next_st.cfg[22:18];
        // Commands carry no row address; spreading rows evenly is left to the issuing software.
        launch = st.link_clk;
        if (launch)
        begin
            next_st.cmd_wr = st.cmd_pend[0];
            next_st.cmd_rd = st.cmd_pend[1] && !st.cmd_pend[0];
            next_st.cmd_pend = st.cmd_pend & (st.cmd_pend[0] ? 2'h2 : 2'h0);
        end
        // A new order is kept even if a launch clears the same cycle.
        if (wr_acc && paddr == `DTC_OFS_CMD)
        begin
            next_st.cmd_pend = next_st.cmd_pend | pwdata[1:0];
        end
        // Observe the device through two flops each.
        next_st.wr_sync = {st.wr_sync[0], link.wr_start};
        next_st.oe_sync = {st.oe_sync[0], link.dqs_oe};
        next_st.wr_seen = st.wr_sync[1];
        next_st.oe_seen = st.oe_sync[1];
        if (st.wr_sync[1] && !st.wr_seen)
        begin
            next_st.wr_count = st.wr_count + 8'h1;
        end
        if (st.oe_sync[1] && !st.oe_seen)
        begin
            next_st.oe_count = st.oe_count + 8'h1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset leaves the link held in reset and idle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The device sees the rounded defaults plus the cfg offsets; latency has no APB register of its own.
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign link.link_clk = st.link_clk;
    assign link.link_rst_n = st.link_rst_n;
    assign link.cmd_wr = st.cmd_wr;
    assign link.cmd_rd = st.cmd_rd;
    assign link.burst_mode = st.cfg[10:9];
    assign link.otf_chop = st.cfg[11];
    assign link.pre2 = st.cfg[12];
    assign link.write_latency_cycles = st.wr_lat;
    assign link.read_latency = st.rd_lat;
endmodule : dtc_ctrl

// *** design/dtc_cfg.svh ***
// Constants for the DRAM timing cycle converter and its link.
// Assumes inclusion by both ends and by the package users.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DTC_OFS_PERIOD  8'h00
`define DTC_OFS_SPD     8'h04
`define DTC_OFS_NONSPD  8'h08
`define DTC_OFS_CFG     8'h0C
`define DTC_OFS_WTR     8'h10
`define DTC_OFS_RFC     8'h14
`define DTC_OFS_SPDCYC  8'h18
`define DTC_OFS_NSPCYC  8'h1C
`define DTC_OFS_RFCCYC  8'h20
`define DTC_OFS_CALCYC  8'h24
`define DTC_OFS_WTRCYC  8'h28
`define DTC_OFS_STATUS  8'h2C
`define DTC_OFS_CMD     8'h30
// ----------------------------------------------------------------
// Arithmetic constants
// ----------------------------------------------------------------
`define DTC_SCALE       48'h3E8
`define DTC_ADJ         48'h3CE
`define DTC_CAL_PS      32'h0EA4
`define DTC_CAL_MIN     32'h3
`define DTC_SLOW_PS     16'h04E2
// ----------------------------------------------------------------
// Link timing constants, in link clock cycles
// ----------------------------------------------------------------
`define DTC_OFS_LONG    5'h4
`define DTC_OFS_SHORT   5'h2
`define DTC_BURST_CK    4'h4
`define DTC_RST_WL      5'h09
`define DTC_RST_RL      5'h0B
`endif

// *** design/dtc_pkg.sv ***
// Types shared by both ends of the DRAM timing cycle converter.
// Assumes dtc_cfg.svh supplies all numeric constants.
package dtc_pkg;
    // Burst mode as fixed in the mode register.
    typedef enum logic [1:0] {
        DTC_BL8_FIXED = 2'h0,
        DTC_BURST_OTF = 2'h1,
        DTC_BC4_FIXED = 2'h2
    } dtc_burst_t;
endpackage : dtc_pkg

// *** design/dtc_link_if.sv ***
// Command link between the controller end and the device end.
// Assumes the controller drives the link clock and link reset.
interface dtc_link_if;
    logic       link_clk;               // Command clock made by the controller.
    logic       link_rst_n;             // Link reset, active low.
    logic       cmd_wr;                 // Write command, one link cycle.
    logic       cmd_rd;                 // Read command, one link cycle.
    logic [1:0] burst_mode;             // Mode register burst setting.
    logic       otf_chop;               // On-the-fly four-beat chop.
    logic       pre2;                   // Two-cycle read preamble.
    logic [4:0] write_latency_cycles;   // Write latency.
    logic [4:0] read_latency;           // Read latency.
    logic       wr_start;               // Internal write start pulse.
    logic       dqs_oe;                 // Data strobe driven by device.
    modport ctrl (output link_clk, link_rst_n, cmd_wr, cmd_rd, burst_mode,
                  otf_chop, pre2, write_latency_cycles, read_latency,
                  input wr_start, dqs_oe);
    modport dev (input link_clk, link_rst_n, cmd_wr, cmd_rd, burst_mode,
                 otf_chop, pre2, write_latency_cycles, read_latency,
                 output wr_start, dqs_oe);
endinterface : dtc_link_if

// *** design/dtc_dev.sv ***
// Device end: internal write start and read strobe timing.
// Assumes commands are launched on the falling link clock edge.
`include "dtc_cfg.svh"
module dtc_dev
    import dtc_pkg::*;
(
    dtc_link_if.dev link,
    output logic    busy
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] wr_cnt;   // Cycles left to internal write.
        logic       wr_start; // Internal write start pulse.
        logic [5:0] rd_cnt;   // Cycles left to strobe drive.
        logic [3:0] oe_cnt;   // Cycles the strobe stays driven.
        logic       dqs_oe;   // Strobe out of high impedance.
        logic       busy;     // Any command in flight.
    } dtc_dev_st_t;

    dtc_dev_st_t st;          // Registered state.
    dtc_dev_st_t next_st;     // Next state.

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Counters count down; a count of one fires the event on the
    // next edge. One command of each kind may be in flight.
    always_comb
    begin
        logic [4:0] ofs;
        logic [4:0] pre;
        ofs = `DTC_OFS_LONG;
        pre = link.pre2 ? 5'h2 : 5'h1;
        next_st = st;
        // Fixed chop starts early; all other bursts start late.
        if (dtc_burst_t'(link.burst_mode) == DTC_BC4_FIXED)
        begin
            ofs = `DTC_OFS_SHORT;
        end
        next_st.wr_start = (st.wr_cnt == 6'h1);
        if (st.wr_cnt != 6'h0)
        begin
            next_st.wr_cnt = st.wr_cnt - 6'h1;
        end
        if (link.cmd_wr)
        begin
            // Latency arrives already rounded to whole cycles.
            next_st.wr_cnt = {1'b0, link.write_latency_cycles} + {1'b0, ofs};
        end
        // Strobe leaves high impedance one cycle per preamble cycle early.
        if (st.rd_cnt != 6'h0)
        begin
            next_st.rd_cnt = st.rd_cnt - 6'h1;
        end
        if (st.oe_cnt != 4'h0)
        begin
            next_st.oe_cnt = st.oe_cnt - 4'h1;
        end
        if (st.rd_cnt == 6'h1)
        begin
            next_st.oe_cnt = pre[3:0] + `DTC_BURST_CK;
        end
        if (link.cmd_rd)
        begin
            next_st.rd_cnt = {1'b0, link.read_latency} - {1'b0, pre};
        end
        next_st.dqs_oe = (next_st.oe_cnt != 4'h0);
        next_st.busy = (next_st.wr_cnt != 6'h0) || (next_st.rd_cnt != 6'h0) || next_st.dqs_oe;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Runs on the link clock; reset comes from the controller.
    always_ff @(posedge link.link_clk or negedge link.link_rst_n)
    begin
        if (!link.link_rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign link.wr_start = st.wr_start;
    assign link.dqs_oe = st.dqs_oe;
    assign busy = st.busy;
endmodule : dtc_dev

// *** dv/dtc_chk.sv ***
// Link timing checker for the cycle converter, link clock domain only.
// Assumes plain copies of the link signals joining the two design ends.
`include "dtc_cfg.svh"
module dtc_chk
    import dtc_pkg::*;
(
    input wire logic       link_clk,
    input wire logic       link_rst_n,
    input wire logic       cmd_wr,
    input wire logic       cmd_rd,
    input wire logic [1:0] burst_mode,
    input wire logic       pre2,
    input wire logic [4:0] write_latency_cycles,
    input wire logic [4:0] read_latency,
    input wire logic       wr_start,
    input wire logic       dqs_oe
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!link_rst_n);
    // --------------------------------------------------------
    // Helper counters
    // --------------------------------------------------------
    logic [5:0] w_cnt;  // Link cycles since the write command was sampled.
    logic [5:0] r_cnt;  // Link cycles since the read command was sampled.
    logic [5:0] w_tgt;  // Cycle at which the write start must be seen.
    logic [5:0] r_tgt;  // Cycle at which the strobe enable must be seen.
    logic       bc4;    // Fixed four-beat chop latched with the write.
    logic       two;    // Two-cycle preamble latched with the read.
    // A new command restarts its count, as the device restarts its own.
    // The counts saturate so a long idle spell cannot wrap into a target.
    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            w_cnt <= '0;
            r_cnt <= '0;
            w_tgt <= '0;
            r_tgt <= '0;
            bc4   <= 1'b0;
            two   <= 1'b0;
        end
        else
        begin
            if (cmd_wr)
            begin
                w_cnt <= 6'h01;
                bc4   <= (burst_mode == DTC_BC4_FIXED);
                w_tgt <= 6'(write_latency_cycles) + ((burst_mode == DTC_BC4_FIXED) ? 6'h03 : 6'h05);
            end
            else if (w_cnt != 6'h00 && w_cnt != 6'h3F)
                w_cnt <= w_cnt + 6'h01;
            if (cmd_rd)
            begin
                r_cnt <= 6'h01;
                two   <= pre2;
                r_tgt <= 6'(read_latency) - 6'(pre2);
            end
            else if (r_cnt != 6'h00 && r_cnt != 6'h3F)
                r_cnt <= r_cnt + 6'h01;
        end
    end
    // A write command is one link cycle long, so the device starts one count per order.
    AST_CMD_PULSE : assert property (cmd_wr |=> !cmd_wr)
        else $error("write command longer than one link cycle");
    // --------------------------------------------------------
    // Sequences and assertions
    // --------------------------------------------------------
    sequence s_oe_one;
        dqs_oe [*5] ##1 !dqs_oe;
    endsequence
    sequence s_oe_two;
        dqs_oe [*6] ##1 !dqs_oe;
    endsequence
    // A zero count means no command yet; the targets are zero then as well.
    AST_WR_LONG : assert property (w_cnt != 6'h00 && w_cnt == w_tgt && !bc4 |-> wr_start)
        else $error("write start missing four cycles after latency");
    AST_WR_SHORT : assert property (w_cnt != 6'h00 && w_cnt == w_tgt && bc4 |-> wr_start)
        else $error("write start missing two cycles after latency");
    AST_WR_WHEN : assert property ($rose(wr_start) |-> w_cnt == w_tgt)
        else $error("write start at the wrong cycle");
    AST_WR_PULSE : assert property (wr_start |=> !wr_start)
        else $error("write start longer than one cycle");
    AST_OE_ONE : assert property (r_cnt != 6'h00 && r_cnt == r_tgt && !two |-> dqs_oe)
        else $error("strobe enable late with one-cycle preamble");
    AST_OE_TWO : assert property (r_cnt != 6'h00 && r_cnt == r_tgt && two |-> dqs_oe)
        else $error("strobe enable late with two-cycle preamble");
    AST_OE_LEN_ONE : assert property ($rose(dqs_oe) && !two |-> s_oe_one)
        else $error("strobe enable length wrong with one-cycle preamble");
    AST_OE_LEN_TWO : assert property ($rose(dqs_oe) && two |-> s_oe_two)
        else $error("strobe enable length wrong with two-cycle preamble");
endmodule : dtc_chk

// *** dv/tb_top.sv ***
// Testbench: converter registers over APB and link timing between both ends.
// Assumes the controller derives the link clock from pclk.
`include "dtc_cfg.svh"
module tb_top
    import dtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk;       // Bus clock, 25 ns.
    logic        presetn;    // Bus reset, active low.
    logic        psel;       // APB select.
    logic        penable;    // APB access phase.
    logic        pwrite;     // APB direction.
    logic [7:0]  paddr;      // APB byte address.
    logic [31:0] pwdata;     // APB write data.
    logic [31:0] prdata;     // APB read data.
    logic        pready;     // APB completion.
    logic        pslverr;    // APB error.
    logic        busy;       // Device command in flight.
    int          err_count;  // Mismatches seen.
    int          tests_run;  // Comparisons made.
    dtc_link_if link ();
    dtc_ctrl u_dtc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
    dtc_dev u_dtc_dev (.link(link.dev), .busy(busy));
    dtc_chk u_dtc_chk (.link_clk(link.link_clk), .link_rst_n(link.link_rst_n), .cmd_wr(link.cmd_wr),
        .cmd_rd(link.cmd_rd), .burst_mode(link.burst_mode), .pre2(link.pre2),
        .write_latency_cycles(link.write_latency_cycles), .read_latency(link.read_latency),
        .wr_start(link.wr_start), .dqs_oe(link.dqs_oe));
    // --------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Compares one 32-bit result with case equality so an unknown bit matches only an unknown bit.
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            err_count++;
            close_out();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    // Loads a period and two parameters, then checks the rounded period, slow flag, presence-detect, other and select counts.
    task automatic t_convert(input logic [31:0] fs, input logic [31:0] prm);
        logic [31:0] r;
        logic [31:0] t;
        t = (fs + 32'h3E7) / 32'h3E8;
        // Period goes last, so the counts must follow a period change alone.
        wr(`DTC_OFS_SPD, prm);
        wr(`DTC_OFS_NONSPD, prm);
        wr(`DTC_OFS_PERIOD, fs);
        repeat (3) @(posedge pclk);
        rd(`DTC_OFS_STATUS, r);
        cmp({16'h0, r[31:16]}, t);
        cmp({31'h0, r[0]}, {31'h0, t > 32'h4E2});
        rd(`DTC_OFS_SPDCYC, r);
        cmp(r, (prm * 32'h3E8 + 32'h3CE * t) / (32'h3E8 * t));
        rd(`DTC_OFS_NSPCYC, r);
        cmp(r, (prm + t - 32'h1) / t);
        rd(`DTC_OFS_CALCYC, r);
        t = (32'hEA4 + t - 32'h1) / t;
        cmp(r, (t > 32'h3) ? t : 32'h3);
    endtask : t_convert
    // Refresh extension and turnaround choice over four settings at 1250 ps.
    task automatic t_refresh();
        logic [31:0] r;
        logic [31:0] cfg [4] = '{32'h43, 32'h41, 32'h42, 32'h0C};
        logic [31:0] rfc [4] = '{32'h11C, 32'h118, 32'h118, 32'h118};
        logic [31:0] wtr [4] = '{32'h6, 32'h6, 32'h6, 32'h8};
        wr(`DTC_OFS_RFC, 32'h55730);
        wr(`DTC_OFS_WTR, 32'h2710_1D4C);
        for (int i = 0; i < 4; i++)
        begin
            wr(`DTC_OFS_CFG, cfg[i]);
            repeat (3) @(posedge pclk);
            rd(`DTC_OFS_RFCCYC, r);
            cmp(r, rfc[i]);
            rd(`DTC_OFS_WTRCYC, r);
            cmp(r, wtr[i]);
        end
    endtask : t_refresh
    // Issues a write and a read, and times both answers on the wire.
    task automatic t_link(input logic [31:0] cfg);
        int k;
        int wg;
        int rg;
        k  = -1;
        wg = 0;
        rg = 0;
        wr(`DTC_OFS_CFG, cfg);
        wr(`DTC_OFS_CMD, 32'h3);
        repeat (120) @(posedge link.link_clk)
        begin
            if (link.cmd_wr === 1'b1)
                k = 0;
            else if (k >= 0)
                k++;
            if (link.wr_start === 1'b1 && wg == 0)
                wg = k;
            if (link.dqs_oe === 1'b1 && rg == 0)
                rg = k;
        end
        cmp(32'(wg), 32'(5'(5'h09 + cfg[17:13])) + ((cfg[10:9] == 2'h2) ? 32'h3 : 32'h5));
        cmp(32'(rg), 32'(5'(5'h0B + cfg[22:18])) + 32'h1 - 32'(cfg[12]));
        cmp({31'h0, busy}, 32'h0);
    endtask : t_link
    // --------------------------------------------------------
    // Clock and main sequence
    // --------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        logic [31:0] r;
        logic        e;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`DTC_OFS_SPDCYC, r);
        cmp(r, 32'h0);
        t_convert(32'h1312D0, 32'h35C0);
        t_refresh();
        t_link(32'h0000_0000);
        t_link(32'h0000_5A00);
        t_link(32'h0004_0400);
        rd(`DTC_OFS_STATUS, r);
        cmp({17'h0, r[15:1]}, 32'h183);
        t_convert(32'h1316B8, 32'h35C0);
        t_convert(32'h105944, 32'h35C0);
        wr(`DTC_OFS_SPDCYC, 32'hFFFF_FFFF);
        rd(`DTC_OFS_SPDCYC, r);
        cmp(r, 32'hD);
        apb(1'b0, 8'h40, 32'h0, r, e);
        cmp({r[31:1], e}, 32'h1);
        close_out();
    end
endmodule : tb_top
